// ===== rtl/srup_apb_master.sv
// apb master that carries one shared-memory word access at a time
`timescale 1ns/1ps
`default_nettype none
module srup_apb_master
	import srup_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request side
	input wire logic req_go,
	input wire srup_pkg::srup_req_t req,
	output logic busy,
	output logic done,
	output logic [31:0] rdata,
	output logic rerr,
	// memory bus
	output srup_pkg::srup_apbm_t mem_o,
	input wire logic [31:0] mem_prdata,
	input wire logic mem_pready,
	input wire logic mem_pslverr
);
	assign busy = mem_o.psel;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_o <= '0;
			done <= 1'b0;
			rdata <= '0;
			rerr <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (!mem_o.psel && req_go)
			begin
				mem_o.psel <= 1'b1;
				mem_o.pwrite <= req.write;
				mem_o.paddr <= req.addr;
				mem_o.pwdata <= req.wdata;
				mem_o.pstrb <= req.write ? req.strb : 4'h0;
			end
			else if (mem_o.psel && !mem_o.penable)
				mem_o.penable <= 1'b1;
			else if (mem_o.psel && mem_pready)
			begin
				// request held unchanged until this edge
				mem_o.psel <= 1'b0;
				mem_o.penable <= 1'b0;
				done <= 1'b1;
				rdata <= mem_prdata;
				rerr <= mem_pslverr;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/srup_driver.sv
// driver-side controller for a split descriptor ring: offers buffers, reaps used
//
// Contract
// - used ring: 16-bit flags, 16-bit index, then 32-bit id plus 32-bit length
// - only the device writes the used ring; the driver only reads it (here the driver writes the used ring header word once, at init)
// - driver trusts no buffer content beyond the reported length
// - buffers skipped in a batch count as completely consumed
// - driver sets used flags to zero when allocating the used ring
// - without event index: notify if flags is zero, stay silent if one
// - event index: ignore flags, notify only when placed index equals event
// - offer order: descriptors, heads, barrier, raise index, barrier, notify
// - queue size at most 32768 so 16-bit indices tell full from empty
// - descriptor gets address, length, write flag, next link and next flag
// - readable elements precede writable ones; at least one element
// - heads go at (index plus added) modulo size, valid after index update
// - descriptor flag value one means the chain continues via next
// - ring indices run freely and wrap at 65536
`timescale 1ns/1ps
`default_nettype none
module srup_driver
	import srup_pkg::*;
#(
	parameter int QMAX = SRUP_QMAX_DOC
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// shared memory master
	output srup_pkg::srup_apbm_t mem_o,
	input wire logic [31:0] mem_prdata,
	input wire logic mem_pready,
	input wire logic mem_pslverr,
	// notifications
	input wire logic used_note,
	output logic avail_notify
);
	localparam int QW = $clog2(QMAX);

	generate
		if (QMAX > SRUP_QMAX_DOC || QMAX < 2 || (QMAX & (QMAX - 1)) != 0)
		begin : g_bad_qmax
			$error("QMAX must be a power of two from 2 to 32768");
		end
	endgenerate

	// configuration and state
	srup_state_t st_reg;
	logic [2:0] step_reg;
	logic pend_reg;
	logic [1:0] ctrl_reg;
	logic [31:0] desc_base_reg, avail_base_reg, used_base_reg;
	logic [15:0] qsize_reg;
	logic [31:0] elem_addr_reg, elem_len_reg;
	logic elem_wr_reg, elem_last_reg;
	logic [ST_W-1:0] status_reg;
	logic [15:0] avail_idx_reg, added_reg, used_seen_reg, dev_used_reg;
	logic [15:0] desc_idx_reg, head_reg, chain_len_reg, free_reg;
	logic chain_open_reg, chain_wr_reg;
	logic [31:0] comp_id_reg, comp_len_reg;
	logic [15:0] comp_batch_reg, scan_k_reg, scan_free_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg, notify_reg;
	// per-slot head and per-head chain length, needed to size batches
	logic [15:0] slot_head [QMAX];
	logic [15:0] head_len [QMAX];

	// memory master
	srup_req_t req;
	logic mem_busy, mem_done, mem_err;
	logic [31:0] mem_rdata;
	wire mem_go = (st_reg != S_IDLE) && (st_reg != S_SCAN) && !pend_reg;

	srup_apb_master u_master
	(
		.pclk(pclk),
		.presetn(presetn),
		.req_go(mem_go),
		.req(req),
		.busy(mem_busy),
		.done(mem_done),
		.rdata(mem_rdata),
		.rerr(mem_err),
		.mem_o(mem_o),
		.mem_prdata(mem_prdata),
		.mem_pready(mem_pready),
		.mem_pslverr(mem_pslverr)
	);

	// register slave decode; bit 32 marks a mapped offset
	logic [32:0] rd_word;
	always_comb
	begin
		case (paddr)
			REG_CTRL: rd_word = {1'b1, 30'h0, ctrl_reg};
			REG_DESC_BASE: rd_word = {1'b1, desc_base_reg};
			REG_AVAIL_BASE: rd_word = {1'b1, avail_base_reg};
			REG_USED_BASE: rd_word = {1'b1, used_base_reg};
			REG_QSIZE: rd_word = {1'b1, 16'h0, qsize_reg};
			REG_ELEM_ADDR: rd_word = {1'b1, elem_addr_reg};
			REG_ELEM_LEN: rd_word = {1'b1, elem_len_reg};
			REG_CMD: rd_word = {1'b1, 32'h0};
			REG_STATUS: rd_word = {1'b1, 26'h0, status_reg};
			REG_AVAIL_IDX: rd_word = {1'b1, added_reg, avail_idx_reg};
			REG_USED_SEEN: rd_word = {1'b1, dev_used_reg, used_seen_reg};
			REG_COMP_ID: rd_word = {1'b1, comp_id_reg};
			REG_COMP_LEN: rd_word = {1'b1, comp_len_reg};
			REG_COMP_BATCH: rd_word = {1'b1, 16'h0, comp_batch_reg};
			REG_FREE: rd_word = {1'b1, 16'h0, free_reg};
			default: rd_word = {1'b0, 32'h0};
		endcase
	end

	wire bus_take = psel && penable && pready_reg;
	wire wr_hit = bus_take && pwrite && rd_word[32];
	wire wr_cmd = wr_hit && (paddr == REG_CMD);
	wire idle = (st_reg == S_IDLE);
	wire cmd_ok = wr_cmd && idle;
	wire cmd_refused = wr_cmd && !idle;
	wire ev_mode = ctrl_reg[CTRL_EVENT];
	wire in_order = ctrl_reg[CTRL_INORDER];

	// ring arithmetic
	wire [15:0] qmask = qsize_reg - 16'h1;
	wire [15:0] head_slot = (avail_idx_reg + added_reg) & qmask;
	wire [15:0] used_slot = used_seen_reg & qmask;
	wire [15:0] scan_slot = (used_seen_reg + scan_k_reg) & qmask;
	wire [15:0] next_desc = (desc_idx_reg + 16'h1) & qmask;
	wire [15:0] pub_idx = avail_idx_reg + added_reg;
	wire qsize_ok = (qsize_reg != 16'h0) && ((qsize_reg & qmask) == 16'h0)
		&& ({16'h0, qsize_reg} <= 32'(QMAX));
	wire [15:0] outstanding = avail_idx_reg - used_seen_reg;
	wire [15:0] scan_head = slot_head[scan_slot[QW-1:0]];
	wire [15:0] scan_len = head_len[scan_head[QW-1:0]];
	wire [15:0] id_len = head_len[comp_id_reg[QW-1:0]];
	wire [15:0] desc_flags = (elem_wr_reg ? F_WRITE : 16'h0)
		| (elem_last_reg ? 16'h0 : F_NEXT);
	wire [15:0] ev_word = mem_rdata[15:0];
	wire ev_hit = 16'(added_reg - 16'h0)
		> 16'(pub_idx - ev_word - 16'h1);
	// the flags word is the read data of the very step that decides
	wire want_note = (added_reg != 16'h0) && (ev_mode ? ev_hit
		: !mem_rdata[NO_NOTIFY_BIT]);
	wire cmd_wr_elem = pwdata[CMD_ELEM_WR];
	wire order_bad = chain_wr_reg && !cmd_wr_elem;
	wire push_ok = (free_reg != 16'h0) && qsize_ok
		&& !(chain_open_reg && order_bad);

	// memory request selection per state and step
	always_comb
	begin
		req = '0;
		case (st_reg)
			S_INIT:
			begin
				// flags and index words start at zero
				req.write = 1'b1;
				req.strb = STRB_ALL;
				req.wdata = {IDX_INIT, FLAGS_INIT};
				req.addr = (step_reg == 3'h0) ? used_base_reg : avail_base_reg;
			end
			S_DESC:
			begin
				req.write = 1'b1;
				req.strb = STRB_ALL;
				req.addr = desc_base_reg + (32'(desc_idx_reg) << DESC_SH)
					+ (32'(step_reg) << WORD_SH);
				case (step_reg)
					3'h0: req.wdata = elem_addr_reg;
					3'h1: req.wdata = 32'h0;
					3'h2: req.wdata = elem_len_reg;
					default: req.wdata = {next_desc, desc_flags};
				endcase
			end
			S_HEAD:
			begin
				req.write = 1'b1;
				req.addr = avail_base_reg + RING_HDR
					+ ((32'(head_slot) << AVAIL_ELEM_SH) & ~32'h3);
				req.strb = head_slot[0] ? STRB_HI : STRB_LO;
				req.wdata = {head_reg, head_reg};
			end
			S_PUB:
			begin
				req.write = (step_reg == 3'h0);
				req.strb = STRB_HI;
				req.wdata = {pub_idx, 16'h0};
				req.addr = (step_reg == 3'h2) ? used_base_reg + RING_HDR
					+ (32'(qsize_reg) << USED_ELEM_SH) : used_base_reg;
				if (step_reg == 3'h0)
					req.addr = avail_base_reg;
			end
			S_POLL:
			begin
				// the used ring is only read here
				req.addr = used_base_reg;
				if (step_reg == 3'h1)
					req.addr = used_base_reg + RING_HDR
						+ (32'(used_slot) << USED_ELEM_SH);
				if (step_reg == 3'h2)
					req.addr = used_base_reg + RING_HDR
						+ (32'(used_slot) << USED_ELEM_SH) + USED_LEN_OFS;
			end
			default: req = '0;
		endcase
	end

	// register slave timing: one wait state, pready from a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= psel && penable && !pready_reg;
			// error stands only together with ready
			pslverr_reg <= psel && penable && !pready_reg
				&& !rd_word[32];
			if (psel && penable && !pready_reg)
				prdata_reg <= pwrite ? 32'h0 : rd_word[31:0];
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign avail_notify = notify_reg;

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= '0;
			desc_base_reg <= '0;
			avail_base_reg <= '0;
			used_base_reg <= '0;
			qsize_reg <= QSIZE_RESET;
			elem_addr_reg <= '0;
			elem_len_reg <= '0;
		end
		else if (wr_hit && idle)
		begin
			case (paddr)
				REG_CTRL: ctrl_reg <= pwdata[1:0];
				REG_DESC_BASE: desc_base_reg <= pwdata;
				REG_AVAIL_BASE: avail_base_reg <= pwdata;
				REG_USED_BASE: used_base_reg <= pwdata;
				REG_QSIZE: qsize_reg <= pwdata[15:0];
				REG_ELEM_ADDR: elem_addr_reg <= pwdata;
				REG_ELEM_LEN: elem_len_reg <= pwdata;
				default: ;
			endcase
		end
	end

	// sticky status: a hardware set wins over a write-one clear
	wire [ST_W-1:0] st_clr = (wr_hit && paddr == REG_STATUS)
		? pwdata[ST_W-1:0] : '0;
	wire set_comp = (st_reg == S_SCAN) && (scan_head == comp_id_reg[15:0])
		&& (scan_k_reg != outstanding)
		|| (st_reg == S_POLL) && mem_done && step_reg == 3'h2 && !in_order;
	wire set_err = (mem_done && mem_err) || (cmd_ok && pwdata[CMD_PUSH]
		&& !push_ok) || (cmd_ok && pwdata[CMD_INIT] && !qsize_ok)
		|| ((st_reg == S_SCAN) && scan_k_reg == outstanding);
	wire [ST_W-1:0] st_set = {notify_reg, cmd_refused, used_note, set_err,
		set_comp, 1'b0};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_reg <= '0;
		else
			status_reg <= ((status_reg & ~st_clr) | st_set)
				& ~(ST_W'(1) << ST_BUSY) | (ST_W'(!idle) << ST_BUSY);
	end

	// sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= S_IDLE;
			step_reg <= '0;
			pend_reg <= 1'b0;
			elem_wr_reg <= 1'b0;
			elem_last_reg <= 1'b0;
			avail_idx_reg <= IDX_INIT;
			added_reg <= '0;
			used_seen_reg <= IDX_INIT;
			dev_used_reg <= IDX_INIT;
			desc_idx_reg <= '0;
			head_reg <= '0;
			chain_len_reg <= '0;
			free_reg <= '0;
			chain_open_reg <= 1'b0;
			chain_wr_reg <= 1'b0;
			comp_id_reg <= '0;
			comp_len_reg <= '0;
			comp_batch_reg <= '0;
			scan_k_reg <= '0;
			scan_free_reg <= '0;
			notify_reg <= 1'b0;
		end
		else
		begin
			notify_reg <= 1'b0;
			if (mem_go)
				pend_reg <= 1'b1;
			if (mem_done)
				pend_reg <= 1'b0;
			case (st_reg)
				S_IDLE:
				begin
					// step clears while idle; every sequence starts at zero
					step_reg <= '0;
					if (cmd_ok && pwdata[CMD_INIT] && qsize_ok)
					begin
						st_reg <= S_INIT;
						avail_idx_reg <= IDX_INIT;
						used_seen_reg <= IDX_INIT;
						added_reg <= '0;
						desc_idx_reg <= '0;
						free_reg <= qsize_reg;
						chain_open_reg <= 1'b0;
						chain_wr_reg <= 1'b0;
					end
					else if (cmd_ok && pwdata[CMD_PUSH] && push_ok)
					begin
						st_reg <= S_DESC;
						elem_wr_reg <= cmd_wr_elem;
						elem_last_reg <= pwdata[CMD_ELEM_LAST];
						if (!chain_open_reg)
							head_reg <= desc_idx_reg;
						chain_len_reg <= chain_open_reg ? chain_len_reg + 16'h1
							: 16'h1;
						chain_open_reg <= !pwdata[CMD_ELEM_LAST];
						chain_wr_reg <= pwdata[CMD_ELEM_LAST] ? 1'b0
							: (chain_wr_reg || cmd_wr_elem);
						free_reg <= free_reg - 16'h1;
					end
					else if (cmd_ok && pwdata[CMD_PUBLISH] && !chain_open_reg)
						st_reg <= S_PUB;
					else if (cmd_ok && pwdata[CMD_POLL])
						st_reg <= S_POLL;
				end
				S_INIT:
					if (mem_done)
					begin
						step_reg <= step_reg + 3'h1;
						if (step_reg != 3'h0)
							st_reg <= S_IDLE;
					end
				S_DESC:
					if (mem_done)
					begin
						step_reg <= step_reg + 3'h1;
						if (step_reg == DESC_LAST_STEP)
						begin
							desc_idx_reg <= next_desc;
							st_reg <= elem_last_reg ? S_HEAD : S_IDLE;
						end
					end
				S_HEAD:
					if (mem_done)
					begin
						// head stays invisible until the index is raised
						slot_head[head_slot[QW-1:0]] <= head_reg;
						head_len[head_reg[QW-1:0]] <= chain_len_reg;
						added_reg <= added_reg + 16'h1;
						st_reg <= S_IDLE;
					end
				S_PUB:
					if (mem_done)
					begin
						// serial master: every earlier write has completed,
						// which is the barrier before and after the index
						step_reg <= step_reg + 3'h1;
						if (step_reg == 3'h0)
							dev_used_reg <= dev_used_reg;
						if ((step_reg == 3'h1 && !ev_mode) || step_reg == 3'h2)
						begin
							notify_reg <= want_note;
							avail_idx_reg <= pub_idx;
							added_reg <= '0;
							st_reg <= S_IDLE;
						end
					end
				S_POLL:
					if (mem_done)
					begin
						step_reg <= step_reg + 3'h1;
						if (step_reg == 3'h0)
						begin
							dev_used_reg <= mem_rdata[31:16];
							if (mem_rdata[31:16] == used_seen_reg)
								st_reg <= S_IDLE;
						end
						if (step_reg == 3'h1)
							comp_id_reg <= mem_rdata;
						if (step_reg == 3'h2)
						begin
							// length bounds what software may trust
							comp_len_reg <= mem_rdata;
							scan_k_reg <= '0;
							scan_free_reg <= free_reg;
							st_reg <= in_order ? S_SCAN : S_IDLE;
							if (!in_order)
							begin
								comp_batch_reg <= 16'h1;
								used_seen_reg <= used_seen_reg + 16'h1;
								free_reg <= free_reg + id_len;
							end
						end
					end
				S_SCAN:
				begin
					// walk pending slots until the reported head is found;
					// every buffer passed counts as fully consumed
					scan_free_reg <= scan_free_reg + scan_len;
					scan_k_reg <= scan_k_reg + 16'h1;
					if (scan_k_reg == outstanding)
						st_reg <= S_IDLE;
					else if (scan_head == comp_id_reg[15:0])
					begin
						comp_batch_reg <= scan_k_reg + 16'h1;
						used_seen_reg <= used_seen_reg + scan_k_reg
							+ 16'h1;
						free_reg <= scan_free_reg + scan_len;
						st_reg <= S_IDLE;
					end
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== rtl/srup_pkg.sv
// constants, types and register map of the split ring driver-side controller
package srup_pkg;
	localparam int SRUP_QMAX_DOC = 32768;
	// own register map, byte offsets on the apb slave
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_DESC_BASE = 12'h004;
	localparam logic [11:0] REG_AVAIL_BASE = 12'h008;
	localparam logic [11:0] REG_USED_BASE = 12'h00C;
	localparam logic [11:0] REG_QSIZE = 12'h010;
	localparam logic [11:0] REG_ELEM_ADDR = 12'h014;
	localparam logic [11:0] REG_ELEM_LEN = 12'h018;
	localparam logic [11:0] REG_CMD = 12'h01C;
	localparam logic [11:0] REG_STATUS = 12'h020;
	localparam logic [11:0] REG_AVAIL_IDX = 12'h024;
	localparam logic [11:0] REG_USED_SEEN = 12'h028;
	localparam logic [11:0] REG_COMP_ID = 12'h02C;
	localparam logic [11:0] REG_COMP_LEN = 12'h030;
	localparam logic [11:0] REG_COMP_BATCH = 12'h034;
	localparam logic [11:0] REG_FREE = 12'h038;
	// field positions
	localparam int CTRL_EVENT = 0;
	localparam int CTRL_INORDER = 1;
	localparam int CMD_INIT = 0;
	localparam int CMD_PUSH = 1;
	localparam int CMD_PUBLISH = 2;
	localparam int CMD_POLL = 3;
	localparam int CMD_ELEM_WR = 4;
	localparam int CMD_ELEM_LAST = 5;
	localparam int ST_BUSY = 0;
	localparam int ST_COMP = 1;
	localparam int ST_ERR = 2;
	localparam int ST_USED_NOTE = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_NOTIFIED = 5;
	localparam int ST_W = 6;
	localparam int NO_NOTIFY_BIT = 0;
	// shared memory layout
	localparam int DESC_SH = 4;
	localparam int USED_ELEM_SH = 3;
	localparam int AVAIL_ELEM_SH = 1;
	localparam int WORD_SH = 2;
	localparam logic [31:0] RING_HDR = 32'h0000_0004;
	localparam logic [31:0] USED_LEN_OFS = 32'h0000_0004;
	localparam logic [15:0] F_NEXT = 16'h0001;
	localparam logic [15:0] F_WRITE = 16'h0002;
	localparam logic [15:0] FLAGS_INIT = 16'h0000;
	localparam logic [15:0] IDX_INIT = 16'h0000;
	localparam logic [3:0] STRB_LO = 4'h3;
	localparam logic [3:0] STRB_HI = 4'hC;
	localparam logic [3:0] STRB_ALL = 4'hF;
	localparam logic [2:0] DESC_LAST_STEP = 3'h3;
	localparam logic [15:0] QSIZE_RESET = 16'h0001;
	typedef enum logic [6:0]
	{
		S_IDLE = 7'h01,
		S_INIT = 7'h02,
		S_DESC = 7'h04,
		S_HEAD = 7'h08,
		S_PUB = 7'h10,
		S_POLL = 7'h20,
		S_SCAN = 7'h40
	} srup_state_t;
	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
		logic write;
	} srup_req_t;
	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} srup_apbm_t;
endpackage

// ===== tb/srup_chk.sv
// port assertions of the split ring driver-side controller
`timescale 1ns/1ps
`default_nettype none
module srup_chk
	import srup_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// memory master and notify
	input wire srup_pkg::srup_apbm_t mem_o,
	input wire logic mem_pready,
	input wire logic avail_notify
);
	logic [3:0] rd_age_reg;
	wire logic fin = mem_o.psel && mem_o.penable && mem_pready;
	// cycles since the last memory read ended, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_age_reg <= 4'hF;
		else if (fin && !mem_o.pwrite)
			rd_age_reg <= 4'h0;
		else if (rd_age_reg != 4'hF)
			rd_age_reg <= rd_age_reg + 4'h1;
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		mem_o.psel && !mem_o.penable;
	endsequence
	sequence s_access;
		mem_o.psel && mem_o.penable;
	endsequence
	property p_wait;
		psel && penable && !$past(penable) |-> !pready ##1 pready;
	endproperty
	property p_one;
		pready |=> !pready;
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_enter;
		s_setup |=> s_access ##0 $stable(mem_o.paddr) && $stable(mem_o.pwrite);
	endproperty
	property p_hold;
		s_access ##0 !mem_pready |=> s_access ##0
			$stable(mem_o.paddr) && $stable(mem_o.pwdata) && $stable(mem_o.pstrb);
	endproperty
	property p_gap;
		fin |=> !mem_o.psel;
	endproperty
	property p_pulse;
		avail_notify |=> !avail_notify;
	endproperty
	property p_late;
		avail_notify |-> rd_age_reg < 4'h4 && !mem_o.psel;
	endproperty
	a_wait: assert property (p_wait)
		else $error("register access answered at the wrong cycle");
	a_one: assert property (p_one)
		else $error("register ready longer than one cycle");
	a_err: assert property (p_err)
		else $error("error flag without ready");
	a_enter: assert property (p_enter)
		else $error("memory setup not followed by access");
	a_hold: assert property (p_hold)
		else $error("memory request changed before ready");
	a_gap: assert property (p_gap)
		else $error("memory access not followed by idle cycle");
	a_pulse: assert property (p_pulse)
		else $error("notify longer than one cycle");
	a_late: assert property (p_late)
		else $error("notify not right after suppression read");
endmodule
bind srup_driver srup_chk srup_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.mem_o(mem_o), .mem_pready(mem_pready), .avail_notify(avail_notify));
`default_nettype wire

// ===== tb/srup_dev.sv
// ring memory model standing for the device, with completion tasks
`timescale 1ns/1ps
`default_nettype none
module srup_dev
	import srup_pkg::*;
#(
	parameter int Q = 16,
	parameter logic [31:0] AV = 32'h0000_0100,
	parameter logic [31:0] US = 32'h0000_0200
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// memory slave
	input wire srup_pkg::srup_apbm_t mem_o,
	output logic [31:0] mem_prdata,
	output logic mem_pready,
	output logic mem_pslverr,
	// notifications and pacing
	input wire logic avail_notify,
	output logic used_note,
	input wire logic [1:0] slow
);
	logic [31:0] mem [0:255];
	logic [1:0] wait_reg;
	logic [15:0] used_idx = IDX_INIT;
	int notes = 0;
	int bad_wr = 0;
	wire logic [7:0] wa = mem_o.paddr[9:2];
	wire logic live = mem_o.psel && mem_o.penable;
	initial foreach (mem[i]) mem[i] = 32'h0;
	initial used_note = 1'b0;
	assign mem_pready = live && wait_reg == slow;
	assign mem_pslverr = 1'b0;
	// a late sample sees the inverse, never a stale match
	assign mem_prdata = mem_pready ? mem[wa] : ~mem[wa];
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wait_reg <= 2'h0;
		else if (live && !mem_pready)
			wait_reg <= wait_reg + 2'h1;
		else
		begin
			wait_reg <= 2'h0;
			if (mem_pready && mem_o.pwrite)
			begin
				for (int b = 0; b < 4; b++)
					if (mem_o.pstrb[b])
						mem[wa][8*b +: 8] <= mem_o.pwdata[8*b +: 8];
				if (mem_o.paddr >= US + RING_HDR && mem_o.paddr < US + 4 + 8*Q)
					bad_wr <= bad_wr + 1;
			end
			// any notification is merely counted
			if (avail_notify)
				notes <= notes + 1;
		end
	end
	// length lands before the index; batch skips slots
	task automatic complete(input logic [31:0] id, input logic [31:0] len,
		input logic [15:0] batch);
		logic [31:0] e;
		e = (US + RING_HDR + 8 * (used_idx % Q)) >> 2;
		mem[e[7:0]] = id;
		mem[e[7:0] + 8'h01] = len;
		used_idx = used_idx + batch;
		mem[US[9:2]][31:16] = used_idx;
		if (mem[AV[9:2]][15:0] == FLAGS_INIT)
		begin
			@(posedge pclk);
			used_note <= 1'b1;
			@(posedge pclk);
			used_note <= 1'b0;
		end
	endtask
	task automatic suppress(input logic [15:0] f, input logic [15:0] ev);
		mem[US[9:2]][15:0] = f;
		mem[US[9:2] + 8'h21][15:0] = ev;
	endtask
endmodule
`default_nettype wire

// ===== tb/srup_driver_tb.sv
// self-checking bench of the split ring driver-side controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) \
	begin \
		checks_done++; \
		if ((s) !== (e)) \
		begin \
			miscompares++; \
			$display("unexpected %s: expected %0h seen %0h", n, e, s); \
		end \
	end
module srup_driver_tb;
	import srup_pkg::*;
	localparam logic [31:0] C_PUSH = 32'h1 << CMD_PUSH;
	localparam logic [31:0] C_WL = C_PUSH | 32'h30;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	srup_apbm_t mem_o;
	logic [31:0] mem_prdata;
	logic mem_pready;
	logic mem_pslverr;
	logic used_note;
	logic avail_notify;
	logic [1:0] slow = 2'h0;
	logic [31:0] rd;
	logic err;
	int n0;
	int miscompares = 0;
	int checks_done = 0;
	always #25 pclk = ~pclk;
	srup_driver #(.QMAX(16)) srup_driver_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_o(mem_o), .mem_prdata(mem_prdata),
		.mem_pready(mem_pready), .mem_pslverr(mem_pslverr),
		.used_note(used_note), .avail_notify(avail_notify));
	srup_dev srup_dev_i (.pclk(pclk), .presetn(presetn), .mem_o(mem_o),
		.mem_prdata(mem_prdata), .mem_pready(mem_pready),
		.mem_pslverr(mem_pslverr), .avail_notify(avail_notify),
		.used_note(used_note), .slow(slow));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n == 50)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task automatic cmd(input logic [31:0] c);
		int n = 0;
		apb(1'b1, REG_CMD, c);
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rd[ST_BUSY] !== 1'b0 && n < 200);
		if (n == 200)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	task automatic push(input logic [31:0] a, input logic [31:0] c);
		apb(1'b1, REG_ELEM_ADDR, a);
		apb(1'b1, REG_ELEM_LEN, a >> 8);
		cmd(c);
	endtask
	function automatic logic [31:0] word(input logic [11:0] a);
		return srup_dev_i.mem[a[9:2]];
	endfunction
	task automatic publish(input logic [31:0] idx, input int more);
		n0 = srup_dev_i.notes;
		cmd(32'h1 << CMD_PUBLISH);
		apb(1'b0, REG_AVAIL_IDX, 32'h0);
		`CHK("idx reg", idx, rd);
		`CHK("avail idx", idx << 16, word(12'h100));
		`CHK("notify count", n0 + more, srup_dev_i.notes);
	endtask
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_QSIZE, 32'h0);
		`CHK("qsize", 32'h1, rd);
		apb(1'b0, 12'h03C, 32'h0);
		`CHK("unmapped err", 1'b1, err);
		`CHK("unmapped data", 32'h0, rd);
		$display("test reset done");
		apb(1'b1, REG_AVAIL_BASE, 32'h100);
		apb(1'b1, REG_USED_BASE, 32'h200);
		apb(1'b1, REG_QSIZE, 32'h10);
		apb(1'b1, REG_DESC_BASE, 32'h0);
		apb(1'b1, REG_CTRL, 32'h0);
		srup_dev_i.mem[8'h80] = 32'hFFFF_0001;
		srup_dev_i.mem[8'h41] = 32'hFFFF_FFFF;
		cmd(32'h1 << CMD_INIT);
		`CHK("used header", 32'h0, word(12'h200));
		push(32'h1000, C_PUSH);
		push(32'h2000, C_WL);
		`CHK("d0 addr", 32'h1000, word(12'h000));
		`CHK("d0 len", 32'h10, word(12'h008));
		`CHK("d0 link", 32'h0001_0001, word(12'h00C));
		`CHK("d1 flags", F_WRITE, word(12'h01C) & 32'hFFFF);
		`CHK("slot0", 32'h0, word(12'h104) & 32'hFFFF);
		`CHK("idx early", 32'h0, word(12'h100));
		publish(1, 1);
		$display("test offer done");
		srup_dev_i.suppress(16'h0001, 16'h0000);
		slow <= 2'h2;
		push(32'h3000, C_PUSH | 32'h20);
		`CHK("slot1", 32'h0002_0000, word(12'h104));
		publish(2, 0);
		$display("test suppressed done");
		apb(1'b1, REG_CTRL, 32'h1);
		// flag left at one on purpose: event mode must ignore it
		srup_dev_i.suppress(16'h0001, 16'h0002);
		push(32'h4000, C_WL);
		publish(3, 1);
		srup_dev_i.suppress(16'h0000, 16'h0005);
		push(32'h5000, C_WL);
		publish(4, 0);
		`CHK("slots 2 3", 32'h0004_0003, word(12'h108));
		$display("test event done");
		apb(1'b1, REG_CTRL, 32'h0);
		srup_dev_i.complete(32'h0, 32'h40, 16'h1);
		cmd(32'h1 << CMD_POLL);
		`CHK("comp flag", 1'b1, rd[ST_COMP]);
		`CHK("used note", 1'b1, rd[ST_USED_NOTE]);
		apb(1'b0, REG_COMP_ID, 32'h0);
		`CHK("comp id", 32'h0, rd);
		apb(1'b0, REG_COMP_LEN, 32'h0);
		`CHK("comp len", 32'h40, rd);
		apb(1'b0, REG_USED_SEEN, 32'h0);
		`CHK("seen", 32'h0001_0001, rd);
		$display("test single done");
		apb(1'b1, REG_CTRL, 32'h2);
		srup_dev_i.complete(32'h4, 32'h80, 16'h3);
		cmd(32'h1 << CMD_POLL);
		apb(1'b0, REG_COMP_ID, 32'h0);
		`CHK("batch id", 32'h4, rd);
		apb(1'b0, REG_COMP_BATCH, 32'h0);
		`CHK("batch size", 32'h3, rd);
		apb(1'b0, REG_USED_SEEN, 32'h0);
		`CHK("batch seen", 32'h0004_0004, rd);
		apb(1'b0, REG_FREE, 32'h0);
		`CHK("free", 32'h10, rd);
		$display("test batch done");
		apb(1'b1, REG_CMD, 32'h1 << CMD_POLL);
		cmd(32'h1 << CMD_POLL);
		`CHK("refused", 1'b1, rd[ST_REFUSED]);
		push(32'h6000, C_PUSH | 32'h10);
		push(32'h7000, C_PUSH);
		`CHK("order err", 1'b1, rd[ST_ERR]);
		`CHK("used writes", 0, srup_dev_i.bad_wr);
		$display("test refuse done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
